/* File: apc_control_regs.sv */
// audio port control register bank behind a two-wire control port
// assumes the control lines are already synchronous to clk_sys
`timescale 1ns/10ps
`default_nettype none
module apc_control_regs (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  input  wire logic [1:0] addrPins,
  output logic            sdaOut,
  output logic            sdaOe,
  output logic      [3:0] auxInSource,
  output logic      [3:0] auxInFormat,
  output logic      [4:0] auxInFrameBits,
  output logic      [3:0] recordSource,
  output logic      [3:0] recordFormat,
  output logic      [4:0] recordWordBits,
  output logic      [3:0] auxOutSource,
  output logic      [3:0] auxOutFormat,
  output logic      [4:0] auxOutWordBits,
  output logic            converterSoftSilence,
  output logic      [6:0] converterExtraDelay,
  output logic            receiverFallbackSource,
  output logic      [9:0] receiverOversampleRatio,
  output logic            autoEmphasisUndo,
  output logic      [2:0] faultAction,
  output logic      [3:0] lockLossAction
);
  apc_pkg::apc_state_e state_r, state_nxt;
  apc_pkg::apc_kind_e  kind_r, kind_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [3:0] bitCnt_r, bitCnt_nxt;
  logic [6:0] regAddr_r, regAddr_nxt;
  logic       readMode_r, readMode_nxt;
  logic       nack_r, nack_nxt;
  logic       sdaOe_nxt;
  logic       sclPrev_r;
  logic       sdaPrev_r;
  logic       startCond, stopCond, sclRise, sclFall, wrEn;
  logic [7:0] rdData;
  logic [7:0] auxIn_r, record_r, auxOut_r, delay_r, rxOne_r;
  logic [7:0] auxIn_nxt, record_nxt, auxOut_nxt, delay_nxt, rxOne_nxt;
  logic       silence_nxt, fallback_nxt, emphasis_nxt;
  logic [6:0] extraDelay_nxt;
  logic [9:0] ratio_nxt;
  logic [2:0] fault_nxt;
  logic [3:0] lockLoss_nxt;

  // line events; start and stop only while the clock line is high
  assign startCond = sclPrev_r & sclIn & sdaPrev_r & ~sdaIn;
  assign stopCond  = sclPrev_r & sclIn & ~sdaPrev_r & sdaIn;
  assign sclRise   = ~sclPrev_r & sclIn;
  assign sclFall   = sclPrev_r & ~sclIn;

  // read mux, unmapped indexes answer zero
  always_comb begin
    case (regAddr_r)
      apc_pkg::REG_AUX_IN:  rdData = auxIn_r;
      apc_pkg::REG_RECORD:  rdData = record_r;
      apc_pkg::REG_AUX_OUT: rdData = auxOut_r;
      apc_pkg::REG_DELAY:   rdData = delay_r;
      apc_pkg::REG_RX_ONE:  rdData = rxOne_r;
      default:              rdData = 8'h00;
    endcase
  end

  // control port sequencer; index auto-increments for block transfers
  always_comb begin
    state_nxt    = state_r;
    kind_nxt     = kind_r;
    shift_nxt    = shift_r;
    bitCnt_nxt   = bitCnt_r;
    regAddr_nxt  = regAddr_r;
    readMode_nxt = readMode_r;
    nack_nxt     = nack_r;
    sdaOe_nxt    = sdaOe;
    wrEn         = 1'b0;
    if (startCond) begin
      // a repeated start keeps the index set by the write phase
      state_nxt  = apc_pkg::ST_RX;
      kind_nxt   = apc_pkg::KIND_DEV;
      bitCnt_nxt = 4'h0;
      sdaOe_nxt  = 1'b0;
    end else if (stopCond) begin
      state_nxt = apc_pkg::ST_IDLE;
      sdaOe_nxt = 1'b0;
    end else begin
      case (state_r)
        apc_pkg::ST_RX: begin
          if (sclRise && bitCnt_r != apc_pkg::BYTE_BITS) begin
            shift_nxt  = {shift_r[6:0], sdaIn};
            bitCnt_nxt = bitCnt_r + 4'h1;
          end else if (sclFall && bitCnt_r == apc_pkg::BYTE_BITS) begin
            bitCnt_nxt = 4'h0;
            state_nxt  = apc_pkg::ST_ACK;
            sdaOe_nxt  = 1'b1;
            case (kind_r)
              apc_pkg::KIND_DEV: begin
                readMode_nxt = shift_r[0];
                kind_nxt     = apc_pkg::KIND_REG;
                if (shift_r[7:1] != {apc_pkg::DEVICE_BASE, addrPins}) begin
                  // not ours: stay off the line until the next start
                  state_nxt = apc_pkg::ST_IDLE;
                  sdaOe_nxt = 1'b0;
                end
              end
              apc_pkg::KIND_REG: begin
                regAddr_nxt = shift_r[7:1];
                kind_nxt    = apc_pkg::KIND_DATA;
              end
              default: begin
                wrEn        = 1'b1;
                regAddr_nxt = regAddr_r + 7'h01;
              end
            endcase
          end
        end
        apc_pkg::ST_ACK, apc_pkg::ST_MACK: begin
          if (sclRise && state_r == apc_pkg::ST_MACK) begin
            nack_nxt = sdaIn;
          end else if (sclFall) begin
            sdaOe_nxt  = 1'b0;
            state_nxt  = apc_pkg::ST_RX;
            bitCnt_nxt = 4'h0;
            if (state_r == apc_pkg::ST_MACK && nack_r) begin
              state_nxt = apc_pkg::ST_IDLE;
            end else if (readMode_r) begin
              shift_nxt   = rdData;
              sdaOe_nxt   = ~rdData[7];
              regAddr_nxt = regAddr_r + 7'h01;
              state_nxt   = apc_pkg::ST_TX;
              nack_nxt    = 1'b0;
            end
          end
        end
        apc_pkg::ST_TX: begin
          if (sclFall) begin
            bitCnt_nxt = bitCnt_r + 4'h1;
            if (bitCnt_r == apc_pkg::LAST_BIT) begin
              sdaOe_nxt = 1'b0;
              state_nxt = apc_pkg::ST_MACK;
            end else begin
              shift_nxt = {shift_r[6:0], 1'b0};
              sdaOe_nxt = ~shift_r[6];
            end
          end
        end
        default: state_nxt = apc_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_r    <= apc_pkg::ST_IDLE;
      kind_r     <= apc_pkg::KIND_DEV;
      shift_r    <= 8'h00;
      bitCnt_r   <= 4'h0;
      regAddr_r  <= 7'h00;
      readMode_r <= 1'b0;
      nack_r     <= 1'b0;
      sdaOe      <= 1'b0;
      sdaOut     <= 1'b0;
      sclPrev_r  <= 1'b1;
      sdaPrev_r  <= 1'b1;
    end else begin
      state_r    <= state_nxt;
      kind_r     <= kind_nxt;
      shift_r    <= shift_nxt;
      bitCnt_r   <= bitCnt_nxt;
      regAddr_r  <= regAddr_nxt;
      readMode_r <= readMode_nxt;
      nack_r     <= nack_nxt;
      sdaOe      <= sdaOe_nxt;
      sdaOut     <= 1'b0; // open drain, only the enable moves
      sclPrev_r  <= sclIn;
      sdaPrev_r  <= sdaIn;
    end
  end

  // register bank; reserved bits are masked so they always read zero
  always_comb begin
    auxIn_nxt  = auxIn_r;
    record_nxt = record_r;
    auxOut_nxt = auxOut_r;
    delay_nxt  = delay_r;
    rxOne_nxt  = rxOne_r;
    if (wrEn) begin
      case (regAddr_r)
        apc_pkg::REG_AUX_IN:  auxIn_nxt  = shift_r & apc_pkg::MASK_AUX_IN;
        apc_pkg::REG_RECORD:  record_nxt = shift_r & apc_pkg::MASK_PORT_OUT;
        apc_pkg::REG_AUX_OUT: auxOut_nxt = shift_r & apc_pkg::MASK_PORT_OUT;
        apc_pkg::REG_DELAY:   delay_nxt  = shift_r & apc_pkg::MASK_FULL;
        apc_pkg::REG_RX_ONE:  rxOne_nxt  = shift_r & apc_pkg::MASK_FULL;
        default:              ; // unmapped writes are dropped
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      auxIn_r  <= apc_pkg::RESET_VALUE;
      record_r <= apc_pkg::RESET_VALUE;
      auxOut_r <= apc_pkg::RESET_VALUE;
      delay_r  <= apc_pkg::RESET_VALUE;
      rxOne_r  <= apc_pkg::RESET_VALUE;
    end else begin
      auxIn_r  <= auxIn_nxt;
      record_r <= record_nxt;
      auxOut_r <= auxOut_nxt;
      delay_r  <= delay_nxt;
      rxOne_r  <= rxOne_nxt;
    end
  end

  // per-port decode, one instance per serial port
  apc_port_decode #(.WIDE_FMT(1'b1)) u_aux_in (
    .clk_sys      (clk_sys),
    .rstn         (rstn),
    .timingSource (auxIn_r[apc_pkg::TS_LSB_AUX_IN +: 2]), // RQ3
    .formatSelect (auxIn_r[2:0]), // RQ4
    .wordSize     (2'h0),
    .sourceOneHot (auxInSource),
    .formatOneHot (auxInFormat),
    .frameBits    (auxInFrameBits)
  );
  apc_port_decode #(.WIDE_FMT(1'b0)) u_record (
    .clk_sys      (clk_sys),
    .rstn         (rstn),
    .timingSource (record_r[apc_pkg::TS_LSB_OUT +: 2]), // RQ1
    .formatSelect ({1'b0, record_r[1:0]}), // RQ6
    .wordSize     (record_r[apc_pkg::OUTPUT_WORD_SIZE_LSB +: 2]), // RQ5
    .sourceOneHot (recordSource),
    .formatOneHot (recordFormat),
    .frameBits    (recordWordBits)
  );
  apc_port_decode #(.WIDE_FMT(1'b0)) u_aux_out (
    .clk_sys      (clk_sys),
    .rstn         (rstn),
    .timingSource (auxOut_r[apc_pkg::TS_LSB_OUT +: 2]), // RQ2
    .formatSelect ({1'b0, auxOut_r[1:0]}), // RQ7
    .wordSize     (auxOut_r[apc_pkg::OUTPUT_WORD_SIZE_LSB +: 2]), // RQ5
    .sourceOneHot (auxOutSource),
    .formatOneHot (auxOutFormat),
    .frameBits    (auxOutWordBits)
  );

  // converter and receiver controls, one flop stage for clean outputs
  always_comb begin
    silence_nxt    = delay_r[apc_pkg::SILENCE_BIT]; // RQ8
    extraDelay_nxt = delay_r[6:0]; // RQ9
    fallback_nxt   = rxOne_r[apc_pkg::FALLBACK_BIT];
    emphasis_nxt   = rxOne_r[apc_pkg::EMPH_BIT]; // RQ15
    case (rxOne_r[apc_pkg::RATIO_LSB +: 2])
      2'h0:    ratio_nxt = apc_pkg::RATIO_128; // RQ12
      2'h1:    ratio_nxt = apc_pkg::RATIO_256;
      2'h2:    ratio_nxt = apc_pkg::RATIO_512;
      default: ratio_nxt = apc_pkg::RATIO_NONE;
    endcase
    // fault action one-hot: bit0 none, bit1 hold, bit2 zero; reserved gives none
    case (rxOne_r[apc_pkg::ERR_LSB +: 2])
      apc_pkg::ACT_HOLD: fault_nxt = 3'h2; // RQ13
      apc_pkg::ACT_ZERO: fault_nxt = 3'h4;
      default:           fault_nxt = 3'h1;
    endcase
    lockLoss_nxt = 4'h1 << rxOne_r[apc_pkg::LOCK_LSB +: 2]; // RQ14
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      converterSoftSilence    <= 1'b0;
      converterExtraDelay     <= 7'h00;
      receiverFallbackSource  <= 1'b0;
      receiverOversampleRatio <= apc_pkg::RATIO_128;
      autoEmphasisUndo        <= 1'b0;
      faultAction             <= 3'h1;
      lockLossAction          <= 4'h1;
    end else begin
      converterSoftSilence    <= silence_nxt;
      converterExtraDelay     <= extraDelay_nxt;
      receiverFallbackSource  <= fallback_nxt;
      receiverOversampleRatio <= ratio_nxt;
      autoEmphasisUndo        <= emphasis_nxt;
      faultAction             <= fault_nxt;
      lockLossAction          <= lockLoss_nxt;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_dataWrite(logic [6:0] idx);
    wrEn && regAddr_r == idx;
  endsequence

  a_silence_write: assert property (s_dataWrite(7'h08)
    |-> ##2 converterSoftSilence == $past(shift_r[7], 2)) // RQ8
    else $error("soft silence did not follow written bit");
  a_delay_write: assert property (s_dataWrite(7'h08)
    |-> ##2 converterExtraDelay == $past(shift_r[6:0], 2)) // RQ9
    else $error("extra delay did not follow written value");
  a_ratio_decode: assert property (rxOne_r[6:5] == 2'h2 |=> receiverOversampleRatio == 10'h200) // RQ12
    else $error("ratio code 10 did not give 512");
  a_fault_hold: assert property (rxOne_r[3:2] == 2'h1 |=> faultAction == 3'h2) // RQ13
    else $error("fault code 01 did not select hold");
  a_lock_mute: assert property (rxOne_r[1:0] == 2'h3 |=> lockLossAction == 4'h8) // RQ14
    else $error("lock code 11 did not select soft mute");
  a_emph_write: assert property (s_dataWrite(7'h09)
    |-> ##2 autoEmphasisUndo == $past(shift_r[4], 2)) // RQ15
    else $error("emphasis undo did not follow written bit");
  a_record_write: assert property (s_dataWrite(7'h06)
    |-> ##2 recordSource == (4'h1 << $past(shift_r[5:4], 2))) // RQ1
    else $error("record source did not follow written code");
  a_idle_quiet: assert property (state_r == apc_pkg::ST_IDLE |-> !sdaOe)
    else $error("data line driven while idle");
endmodule : apc_control_regs
`default_nettype wire

/* File: apc_pkg.sv */
// audio port control: shared constants, field layout and state types
// assumes a single 125 MHz clk_sys domain and a two-wire control port
// What the document requires
// RQ1 - record timing source: 00 slave, 01 PLL, 10 clock one, 11 clock two
// RQ2 - aux output timing source: 00 slave, 01 PLL, 10 clock one, 11 two
// RQ3 - aux input timing source: 00 slave, 01 PLL, 10 clock one, 11 two
// RQ4 - aux input format: 000 left, 001 I2S, 1xx right-justified 24/20/18/16
// RQ5 - output word size code 00..11 gives 24, 20, 18, 16 bits
// RQ6 - record format: 00 left, 01 I2S, 11 right-justified, 10 reserved
// RQ7 - aux output format: 00 left, 01 I2S, 11 right, 10 reserved
// RQ8 - converter soft silence bit set ramps converter output to mute
// RQ9 - seven-bit extra delay adds 0 to 127 samples to converter filter
// RQ10 - in slave mode the far party drives frame sync and bit strobe
// RQ11 - software avoids reserved codes and writes zero to reserved bits; the bench writes ones there and uses reserved codes
// RQ12 - oversample ratio: 00 gives 128, 01 256, 10 512 times fs
// RQ13 - on parity or biphase fault: none, hold last, or zero samples
// RQ14 - on lost lock: none, hold last, zeros, or soft-mute last sample
// RQ15 - auto emphasis undo bit enables de-emphasis from channel status
package apc_pkg;
  // register indexes on the control port
  localparam logic [6:0] REG_AUX_IN  = 7'h05;
  localparam logic [6:0] REG_RECORD  = 7'h06;
  localparam logic [6:0] REG_AUX_OUT = 7'h07;
  localparam logic [6:0] REG_DELAY   = 7'h08;
  localparam logic [6:0] REG_RX_ONE  = 7'h09;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  // writable bits, reserved bits stay zero
  localparam logic [7:0] MASK_AUX_IN   = 8'h1F;
  localparam logic [7:0] MASK_PORT_OUT = 8'h3F;
  localparam logic [7:0] MASK_FULL     = 8'hFF;
  // fixed part of the control port device address
  localparam logic [4:0] DEVICE_BASE = 5'h04;
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [3:0] LAST_BIT    = 4'h7;
  // field positions
  localparam int TS_LSB_AUX_IN = 3;
  localparam int TS_LSB_OUT    = 4;
  localparam int OUTPUT_WORD_SIZE_LSB      = 2;
  localparam int SILENCE_BIT   = 7;
  localparam int FALLBACK_BIT  = 7;
  localparam int RATIO_LSB     = 5;
  localparam int EMPH_BIT      = 4;
  localparam int ERR_LSB       = 2;
  localparam int LOCK_LSB      = 0;
  // timing source codes, one-hot bit order matches the code value
  localparam logic [1:0] TS_SLAVE = 2'h0;
  localparam logic [1:0] TS_PLL   = 2'h1;
  localparam logic [1:0] TS_INTERNAL_CLOCK_ONE = 2'h2;
  localparam logic [1:0] TS_INTERNAL_CLOCK_TWO = 2'h3;
  // three-bit input format codes
  localparam logic [2:0] FMT3_LEFT = 3'h0;
  localparam logic [2:0] FMT3_I2S  = 3'h1;
  localparam logic [2:0] FMT3_RJ24 = 3'h4;
  localparam logic [2:0] FMT3_RJ20 = 3'h5;
  localparam logic [2:0] FMT3_RJ18 = 3'h6;
  localparam logic [2:0] FMT3_RJ16 = 3'h7;
  // two-bit output format codes
  localparam logic [1:0] FMT2_LEFT = 2'h0;
  localparam logic [1:0] FMT2_I2S  = 2'h1;
  localparam logic [1:0] FMT2_RJ   = 2'h3;
  // format one-hot: bit0 left, bit1 I2S, bit2 right, bit3 reserved
  localparam logic [3:0] FMT_OH_LEFT  = 4'h1;
  localparam logic [3:0] FMT_OH_I2S   = 4'h2;
  localparam logic [3:0] FMT_OH_RIGHT = 4'h4;
  localparam logic [3:0] FMT_OH_RSVD  = 4'h8;
  // word lengths in bits
  localparam logic [4:0] BITS_24 = 5'h18;
  localparam logic [4:0] BITS_20 = 5'h14;
  localparam logic [4:0] BITS_18 = 5'h12;
  localparam logic [4:0] BITS_16 = 5'h10;
  // receiver clock multiples of fs, zero marks the reserved code
  localparam logic [9:0] RATIO_128 = 10'h080;
  localparam logic [9:0] RATIO_256 = 10'h100;
  localparam logic [9:0] RATIO_512 = 10'h200;
  localparam logic [9:0] RATIO_NONE = 10'h000;
  // receiver fault action codes
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_HOLD = 2'h1;
  localparam logic [1:0] ACT_ZERO = 2'h2;
  localparam logic [1:0] ACT_MUTE = 2'h3;
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} apc_state_e;
  typedef enum logic [1:0] {KIND_DEV, KIND_REG, KIND_DATA} apc_kind_e;
endpackage : apc_pkg

/* File: apc_port_decode.sv */
// one serial port: decodes timing source, format and word size to flops
// assumes the field values come from the register bank in the same clock
`timescale 1ns/10ps
`default_nettype none
module apc_port_decode #(
  parameter bit WIDE_FMT = 1'b0
) (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic [1:0] timingSource,
  input  wire logic [2:0] formatSelect,
  input  wire logic [1:0] wordSize,
  output logic      [3:0] sourceOneHot,
  output logic      [3:0] formatOneHot,
  output logic      [4:0] frameBits
);
  logic [3:0] sourceOneHot_nxt;
  logic [3:0] formatOneHot_nxt;
  logic [4:0] frameBits_nxt;
  logic [4:0] wordBits;

  // word length, used by right-justified output framing
  always_comb begin
    case (wordSize)
      2'h0:    wordBits = apc_pkg::BITS_24; // RQ5
      2'h1:    wordBits = apc_pkg::BITS_20;
      2'h2:    wordBits = apc_pkg::BITS_18;
      default: wordBits = apc_pkg::BITS_16;
    endcase
  end

  // source and framing decode
  always_comb begin
    sourceOneHot_nxt = 4'h1 << timingSource; // RQ1 RQ2 RQ3
    formatOneHot_nxt = apc_pkg::FMT_OH_RSVD;
    frameBits_nxt    = wordBits; // RQ5
    if (WIDE_FMT) begin
      // input ports carry their right-justified width in the format code
      case (formatSelect)
        apc_pkg::FMT3_LEFT: formatOneHot_nxt = apc_pkg::FMT_OH_LEFT; // RQ4
        apc_pkg::FMT3_I2S:  formatOneHot_nxt = apc_pkg::FMT_OH_I2S;
        apc_pkg::FMT3_RJ24: formatOneHot_nxt = apc_pkg::FMT_OH_RIGHT;
        apc_pkg::FMT3_RJ20: formatOneHot_nxt = apc_pkg::FMT_OH_RIGHT;
        apc_pkg::FMT3_RJ18: formatOneHot_nxt = apc_pkg::FMT_OH_RIGHT;
        apc_pkg::FMT3_RJ16: formatOneHot_nxt = apc_pkg::FMT_OH_RIGHT;
        default:            formatOneHot_nxt = apc_pkg::FMT_OH_RSVD;
      endcase
      case (formatSelect)
        apc_pkg::FMT3_RJ20: frameBits_nxt = apc_pkg::BITS_20; // RQ4
        apc_pkg::FMT3_RJ18: frameBits_nxt = apc_pkg::BITS_18;
        apc_pkg::FMT3_RJ16: frameBits_nxt = apc_pkg::BITS_16;
        default:            frameBits_nxt = apc_pkg::BITS_24;
      endcase
    end else begin
      case (formatSelect[1:0])
        apc_pkg::FMT2_LEFT: formatOneHot_nxt = apc_pkg::FMT_OH_LEFT; // RQ6 RQ7
        apc_pkg::FMT2_I2S:  formatOneHot_nxt = apc_pkg::FMT_OH_I2S;
        apc_pkg::FMT2_RJ:   formatOneHot_nxt = apc_pkg::FMT_OH_RIGHT;
        default:            formatOneHot_nxt = apc_pkg::FMT_OH_RSVD;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sourceOneHot <= 4'h1;
      formatOneHot <= apc_pkg::FMT_OH_LEFT;
      frameBits    <= apc_pkg::BITS_24;
    end else begin
      sourceOneHot <= sourceOneHot_nxt;
      formatOneHot <= formatOneHot_nxt;
      frameBits    <= frameBits_nxt;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_src_onehot: assert property ($onehot(sourceOneHot)) // RQ1 RQ2 RQ3
    else $error("timing source select not one-hot");
  a_src_slave: assert property ($stable(timingSource) && timingSource == apc_pkg::TS_SLAVE
    |=> sourceOneHot == 4'h1) // RQ1 RQ2 RQ3
    else $error("slave code did not select slave timing");
  a_src_clk_two: assert property (timingSource == apc_pkg::TS_INTERNAL_CLOCK_TWO
    |=> sourceOneHot[3]) // RQ1 RQ2 RQ3
    else $error("code 11 did not select internal clock two");
  a_word_size: assert property (!WIDE_FMT && wordSize == 2'h3 |=> frameBits == 5'h10) // RQ5
    else $error("word size 11 did not give 16 bits");
  a_fmt_reserved: assert property (!WIDE_FMT && formatSelect[1:0] == 2'h2
    |=> formatOneHot == 4'h8) // RQ6 RQ7
    else $error("reserved output format not flagged");
  a_fmt_rj_wide: assert property (WIDE_FMT && formatSelect == 3'h6
    |=> formatOneHot == 4'h4 && frameBits == 5'h12) // RQ4
    else $error("code 110 did not give 18-bit right-justified");
endmodule : apc_port_decode
`default_nettype wire

/* File: apc_i2c_host.sv */
// two-wire control port host model: drives the clock, pulls data low
// assumes the bench resolves the open-drain data line with a pull-up
`timescale 1ns/10ps
`default_nettype none
module apc_i2c_host (
  input  wire logic clk_sys,
  input  wire logic sdaLine,
  output logic      sclOut,
  output logic      sdaPull
);
  // idle bus: clock high, data released
  initial begin
    sclOut = 1'b1;
    sdaPull = 1'b0;
  end
  // four cycles per level, well above the two-cycle floor
  task automatic half;
    repeat (4) @(negedge clk_sys);
  endtask : half
  // data moves only while the clock is low, one cycle after its fall
  task automatic bitx(input logic b, output logic r);
    sdaPull = ~b;
    half();
    sclOut = 1'b1;
    half();
    r = sdaLine;
    sclOut = 1'b0;
    @(negedge clk_sys);
  endtask : bitx
  // start and repeated start alike
  task automatic start;
    sdaPull = 1'b0;
    half();
    sclOut = 1'b1;
    half();
    sdaPull = 1'b1;
    half();
    sclOut = 1'b0;
    // hold data one cycle past the clock fall before the first bit
    @(negedge clk_sys);
  endtask : start
  task automatic stop;
    sdaPull = 1'b1;
    half();
    sclOut = 1'b1;
    half();
    sdaPull = 1'b0;
    half();
  endtask : stop
  // byte out, then releases data for the acknowledge
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask : send
  // byte in; last releases data so the device sees a nack
  task automatic recv(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(last, r);
  endtask : recv
endmodule : apc_i2c_host
`default_nettype wire

/* File: apc_control_regs_bench.sv */
// self-checking bench for the audio port control register bank
// assumes the host model as control port master and address pins at 2
`timescale 1ns/10ps
`default_nettype none
module apc_control_regs_bench;
  localparam logic [6:0] DEV = 7'h12;
  // index, data written, value read back (reserved bits drop to zero)
  localparam logic [23:0] ROWS [21] = '{24'h05E000, 24'h050909, 24'h051414,
    24'h051D1D, 24'h050606, 24'h050707, 24'h050202, 24'h06C000, 24'h061515,
    24'h062A2A, 24'h063F3F, 24'h071515, 24'h072A2A, 24'h073F3F, 24'h070000,
    24'h088080, 24'h087F7F, 24'h090000, 24'h095555, 24'h09AAAA, 24'h09FFFF};
  logic       clk_sys, rstn, sclLine, sdaPull, sdaOe, sdaOut, sdaLine, a;
  logic [3:0] auxInSource, auxInFormat, recordSource, recordFormat, lockLossAction;
  logic [3:0] auxOutSource, auxOutFormat;
  logic [4:0] auxInFrameBits, recordWordBits, auxOutWordBits;
  logic [9:0] receiverOversampleRatio;
  logic [6:0] converterExtraDelay;
  logic [2:0] faultAction;
  logic       converterSoftSilence, receiverFallbackSource, autoEmphasisUndo;
  logic [7:0] d0, d1;
  int         nFail, testsRun;
  // pull-up on the shared data line; the device drives its level only when enabled
  assign sdaLine = ~sdaPull & (~sdaOe | sdaOut);
  apc_control_regs dut_u (.clk_sys, .rstn, .sclIn(sclLine), .sdaIn(sdaLine),
    .addrPins(2'h2), .sdaOut, .sdaOe, .auxInSource, .auxInFormat, .auxInFrameBits,
    .recordSource, .recordFormat, .recordWordBits, .auxOutSource, .auxOutFormat,
    .auxOutWordBits, .converterSoftSilence, .converterExtraDelay, .receiverFallbackSource,
    .receiverOversampleRatio, .autoEmphasisUndo, .faultAction, .lockLossAction);
  apc_i2c_host hostU (.clk_sys, .sdaLine, .sclOut(sclLine), .sdaPull);
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // expected decodes worked out from the field codes
  function automatic logic [4:0] wb(input logic [1:0] c);
    return (c == 2'h0) ? 5'h18 : (c == 2'h1) ? 5'h14 : (c == 2'h2) ? 5'h12 : 5'h10;
  endfunction : wb
  function automatic logic [3:0] f2(input logic [1:0] c);
    return (c == 2'h2) ? 4'h8 : (c == 2'h3) ? 4'h4 : (4'h1 << c);
  endfunction : f2
  function automatic logic [3:0] f3(input logic [2:0] c);
    return c[2] ? 4'h4 : (c[1] ? 4'h8 : (4'h1 << c[0]));
  endfunction : f3
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    testsRun++;
    if (g !== e) begin
      nFail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic chk(input logic [6:0] idx, input logic [7:0] v);
    case (idx)
      7'h05: cmp("auxIn", {4'h1 << v[4:3], f3(v[2:0]), v[2] ? wb(v[1:0]) : 5'h18},
        {auxInSource, auxInFormat, auxInFrameBits});
      7'h06: cmp("record", {4'h1 << v[5:4], f2(v[1:0]), wb(v[3:2])},
        {recordSource, recordFormat, recordWordBits});
      7'h07: cmp("auxOut", {4'h1 << v[5:4], f2(v[1:0]), wb(v[3:2])},
        {auxOutSource, auxOutFormat, auxOutWordBits});
      7'h08: cmp("converter", v, {converterSoftSilence, converterExtraDelay});
      default: cmp("receiver", {v[7], (v[6:5] == 2'h3) ? 10'h000 : (10'h080 << v[6:5]), v[4],
        (v[3:2] == 2'h3) ? 3'h1 : (3'h1 << v[3:2]), 4'h1 << v[1:0]}, {receiverFallbackSource,
        receiverOversampleRatio, autoEmphasisUndo, faultAction, lockLossAction});
    endcase
  endtask : chk
  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    logic a0, a1, a2;
    hostU.start();
    hostU.send({DEV, 1'b0}, a0);
    hostU.send({idx, 1'b0}, a1);
    hostU.send(d, a2);
    hostU.stop();
    cmp("write ack", 1, a0 & a1 & a2);
    repeat (2) @(negedge clk_sys);
  endtask : wr
  // point with a write frame, then repeated start and read
  task automatic rd(input logic [6:0] idx, input logic last, output logic [7:0] d);
    logic a0, a1, a2;
    hostU.start();
    hostU.send({DEV, 1'b0}, a0);
    hostU.send({idx, 1'b0}, a1);
    hostU.start();
    hostU.send({DEV, 1'b1}, a2);
    hostU.recv(last, d);
    cmp("read ack", 1, a0 & a1 & a2);
  endtask : rd
  task automatic stop_test;
    $display("checks %0d mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  initial begin
    repeat (100000) @(posedge clk_sys);
    nFail++;
    $display("Error watchdog expected done seen hang");
    stop_test();
  end
  initial begin
    rstn = 1'b0;
    nFail = 0;
    testsRun = 0;
    repeat (5) @(negedge clk_sys);
    rstn = 1'b1;
    @(negedge clk_sys);
    foreach (ROWS[i]) begin
      wr(ROWS[i][22:16], ROWS[i][15:8]);
      chk(ROWS[i][22:16], ROWS[i][7:0]);
      rd(ROWS[i][22:16], 1'b1, d0);
      hostU.stop();
      cmp("readback", ROWS[i][7:0], d0);
    end
    $display("field table test done");
    // block write then block read across the last two registers
    hostU.start();
    hostU.send({DEV, 1'b0}, a);
    hostU.send(8'h10, a);
    hostU.send(8'h85, a);
    hostU.send(8'h3C, a);
    hostU.stop();
    repeat (2) @(negedge clk_sys);
    rd(7'h08, 1'b0, d0);
    hostU.recv(1'b1, d1);
    hostU.stop();
    cmp("block read", 16'h853C, {d0, d1});
    chk(7'h08, 8'h85);
    chk(7'h09, 8'h3C);
    $display("block test done");
    // a foreign device address must stay unanswered
    hostU.start();
    hostU.send({7'h13, 1'b0}, a);
    hostU.stop();
    cmp("foreign ack", 0, a);
    // the playback index lies outside this bank
    wr(7'h04, 8'h5A);
    rd(7'h04, 1'b1, d0);
    hostU.stop();
    cmp("unmapped read", 8'h00, d0);
    $display("refusal test done");
    // second reset in mid-run returns every field to its default
    rstn = 1'b0;
    repeat (2) @(negedge clk_sys);
    rstn = 1'b1;
    @(negedge clk_sys);
    for (int k = 5; k <= 9; k++) begin
      chk(k[6:0], 8'h00);
      rd(k[6:0], 1'b1, d0);
      hostU.stop();
      cmp("reset value", 8'h00, d0);
    end
    $display("reset test done");
    stop_test();
  end
endmodule : apc_control_regs_bench
`default_nettype wire
